/* File: hdl/conv_ctrl_params.svh */
// constants of the converter sequencer
// assumes a 100 MHz pclk and a 32-bit apb port
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// register byte addresses
`define OFS_CONFIG0 12'h000
`define OFS_CONFIG1 12'h004
`define OFS_CONFIG2 12'h008
`define OFS_STATUS 12'h00C
`define OFS_RESULT 12'h010
`define OFS_COMMAND 12'h014

// config0 fields
`define F_INPUT_SELECT_HI 7
`define F_INPUT_SELECT_LO 4
`define F_GAIN_HI 3
`define F_GAIN_LO 1
`define F_GAIN_BYPASS 0
// config1 fields
`define F_DATA_RATE_HI 7
`define F_DATA_RATE_LO 5
`define F_OP_MODE_HI 4
`define F_OP_MODE_LO 3
`define F_CONVERSION_MODE 2
`define F_TEMP_SENSOR 1
// config2 fields
`define F_REF_SELECT_HI 7
`define F_REF_SELECT_LO 6
`define F_READY_ON_DOUT 1
`define F_SWITCH_ENABLE 0
// command register bits
`define F_CMD_START 0
`define F_CMD_SLEEP 1

// reset values
`define RST_CONFIG0 8'h00
`define RST_CONFIG1 8'h00
`define RST_CONFIG2 8'h00

// input select codes and the internal reference code
`define MUX_REF_MONITOR 4'h0C
`define MUX_SUPPLY_MONITOR 4'h0D
`define MUX_OFFSET_SHORT 4'h0E
`define REF_INTERNAL 2'h0

// serial commands, low bit ignored
`define CMD_START 7'h04
`define CMD_SLEEP 7'h01

// timing and temperature code width
`define SYS_CLK_MHZ 100
`define POR_TIME_US 50
`define POR_CYCLES (`POR_TIME_US * `SYS_CLK_MHZ)
`define START_DELAY_NORMAL 210
`define START_DELAY_TURBO 114
`define DIV_NORMAL 16
`define DIV_TURBO 8
`define DUTY_IDLE_PERIODS 3
`define TEMP_BITS 14

`endif

/* File: hdl/conv_ctrl_pkg.sv */
// types shared by the converter sequencer
// assumes the numbers live in conv_ctrl_params.svh
package conv_ctrl_pkg;

    typedef enum logic [1:0] {
        op_normal = 2'b00,
        op_duty = 2'b01,
        op_turbo = 2'b10
    } op_mode_type;

    typedef enum logic [5:0] {
        st_por = 6'b000001,
        st_delay = 6'b000010,
        st_convert = 6'b000100,
        st_duty_wait = 6'b001000,
        st_idle = 6'b010000,
        st_down = 6'b100000
    } seq_state_type;

    // settings handed to the analog front end
    typedef struct packed {
        logic [3:0] input_select_field;
        logic [2:0] gain;
        logic gain_bypass;
        logic [1:0] ref_select;
        logic measure_temp;
        logic powered;
        logic osc_on;
        logic excitation_enable;
        logic switch_closed;
    } afe_ctrl_type;

    // three-stage pin synchroniser outputs
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } spi_pins_type;

endpackage : conv_ctrl_pkg

/* File: hdl/conv_ctrl.sv */
// sequencer of a 16-bit delta-sigma converter
// power-up, modes, monitors, serial commands, results
// assumes pclk is the system clock and the front end hands raw codes
// on afe_sample and afe_temp_code; registers sit behind apb
//
// Notes on behaviour
// - monitor channel bypasses the amplifier and forces gain of one
// - supply monitor code 1101 always uses the internal reference
// - code 1100 measures the selected reference pair and keeps the selected reference
// - an input select code shorts both amplifier inputs to mid-supply
// - temperature mode ignores config0 and uses the internal reference
// - temperature result is 14-bit left-justified, msb byte first
// - power-up reset of about 50 us loads defaults before communication
// - after power-up one default single conversion, then low power, ready falls
// - conversion mode bit set to one selects continuous conversions
// - single-shot converts once per start, then oscillator and analog off
// - single-shot config write starts or restarts one fresh conversion
// - continuous mode stores result and starts next conversion at once
// - continuous starts on start command after 210 or 114 clock periods
// - continuous mode config write restarts the ongoing conversion
// - normal mode default, modulator at clock over 16, rate from data rate field
// - duty-cycle converts as normal then idles three conversion periods
// - turbo mode runs the modulator at clock over 8
// - sleep finishes ongoing conversion, then powers down keeping configuration
// - start in power-down wakes and follows the conversion mode bit
// - config write in power-down wakes and starts exactly one conversion
// - serial port is spi mode 1; ready may also show on data out
// - ready output falls on new result, rises on next serial clock rising edge
// - start byte is 0000 100x, sleep byte is 0000 001x
// - analog results are 16-bit twos complement
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_params.svh"

module conv_ctrl #(
    parameter int unsigned por_cycles = `POR_CYCLES,
    parameter int unsigned conv_div = 1
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic serial_out_ready_n,
    output logic serial_out_ready_n_oe,
    output logic result_ready_n,
    // analog front end
    input wire logic [15:0] afe_sample,
    input wire logic [13:0] afe_temp_code,
    output conv_ctrl_pkg::afe_ctrl_type afe_ctrl,
    output logic modulator_tick
);

    generate
        if (conv_div < 1 || conv_div > 2072) begin : g_bad_div
            $error("conv_div must lie between 1 and 2072");
        end
        if (por_cycles < 1) begin : g_bad_por
            $error("por_cycles must be at least 1");
        end
    endgenerate

    // register file
    logic [7:0] config0;
    logic [7:0] config1;
    logic [7:0] config2;
    logic [15:0] result;

    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite;
    wire sel_cfg0 = paddr == `OFS_CONFIG0;
    wire sel_cfg1 = paddr == `OFS_CONFIG1;
    wire sel_cfg2 = paddr == `OFS_CONFIG2;
    wire sel_status = paddr == `OFS_STATUS;
    wire sel_result = paddr == `OFS_RESULT;
    wire sel_cmd = paddr == `OFS_COMMAND;
    wire sel_any = sel_cfg0 || sel_cfg1 || sel_cfg2 || sel_status || sel_result || sel_cmd;

    conv_ctrl_pkg::seq_state_type state;
    conv_ctrl_pkg::seq_state_type next_state;
    wire in_por = state == conv_ctrl_pkg::st_por;
    // no access during power-up
    wire apb_ok = sel_any && !in_por;
    wire cfg_write = apb_wr && apb_ok && (sel_cfg0 || sel_cfg1 || sel_cfg2);

    // config fields
    wire [3:0] input_select_field = config0[`F_INPUT_SELECT_HI:`F_INPUT_SELECT_LO];
    wire [2:0] data_rate_field = config1[`F_DATA_RATE_HI:`F_DATA_RATE_LO];
    wire [1:0] op_mode_raw = config1[`F_OP_MODE_HI:`F_OP_MODE_LO];
    wire conversion_mode_bit = config1[`F_CONVERSION_MODE];
    wire temp_sensor_enable = config1[`F_TEMP_SENSOR];
    wire [1:0] ref_select = config2[`F_REF_SELECT_HI:`F_REF_SELECT_LO];
    wire ready_on_dout = config2[`F_READY_ON_DOUT];
    wire switch_enable = config2[`F_SWITCH_ENABLE];
    wire turbo = op_mode_raw == conv_ctrl_pkg::op_turbo;
    wire duty = op_mode_raw == conv_ctrl_pkg::op_duty;

    // serial pin synchronisers: first stage feeds only the second
    conv_ctrl_pkg::spi_pins_type pin_s1;
    conv_ctrl_pkg::spi_pins_type pin_s2;
    conv_ctrl_pkg::spi_pins_type pin_s3;
    conv_ctrl_pkg::spi_pins_type pin_q;
    conv_ctrl_pkg::spi_pins_type next_pin_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 3'b100;
            pin_s2 <= 3'b100;
            pin_s3 <= 3'b100;
            pin_q <= 3'b100;
        end else begin
            pin_s1 <= '{cs_n: cs_n, sclk: sclk, din: din};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q <= next_pin_q;
        end
    end

    // a pin change counts once the second and third stages agree
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_pin
            assign next_pin_q[gp] = (pin_s2[gp] == pin_s3[gp]) ? pin_s3[gp] : pin_q[gp];
        end
    endgenerate

    wire selected = !pin_q.cs_n;
    wire sclk_rise = selected && !pin_q.sclk && next_pin_q.sclk;
    wire sclk_fall = selected && pin_q.sclk && !next_pin_q.sclk;
    wire cs_fall = pin_q.cs_n && !next_pin_q.cs_n;

    // mode 1: din taken on falls, data out shifted on rises
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [15:0] tx_shift;
    logic tx_active;
    wire [7:0] rx_byte = {rx_shift[6:0], next_pin_q.din};
    wire byte_done = sclk_fall && bit_cnt == 3'd7;
    wire spi_start = byte_done && rx_byte[7:1] == `CMD_START;
    wire spi_sleep = byte_done && rx_byte[7:1] == `CMD_SLEEP;
    wire start_cmd = spi_start || (apb_wr && apb_ok && sel_cmd && pwdata[`F_CMD_START]);
    wire sleep_cmd = spi_sleep || (apb_wr && apb_ok && sel_cmd && pwdata[`F_CMD_SLEEP]);

    // clocks per conversion and data rate, shortened by conv_div
    function automatic logic [31:0] conv_len(input logic [2:0] rate, input logic fast);
        logic [31:0] n;
        n = 32'h0000_0000;
        case (rate)
            3'd0: n = fast ? 32'd102384 : 32'd204768;
            3'd1: n = fast ? 32'd45560 : 32'd91120;
            3'd2: n = fast ? 32'd23064 : 32'd46128;
            3'd3: n = fast ? 32'd11832 : 32'd23664;
            3'd4: n = fast ? 32'd6232 : 32'd12464;
            3'd5: n = fast ? 32'd3448 : 32'd6896;
            default: n = fast ? 32'd2072 : 32'd4144;
        endcase
        conv_len = n / conv_div;
    endfunction

    wire [31:0] conv_cycles = conv_len(data_rate_field, turbo);
    wire [31:0] duty_cycles = conv_cycles * `DUTY_IDLE_PERIODS;
    wire [31:0] start_delay = turbo ? `START_DELAY_TURBO : `START_DELAY_NORMAL;
    wire [4:0] mod_div = turbo ? 5'(`DIV_TURBO) : 5'(`DIV_NORMAL);

    logic [31:0] count;
    logic continuous_run;
    logic sleep_pending;
    wire count_done = count == 32'h0000_0000;
    wire converting = state == conv_ctrl_pkg::st_convert || state == conv_ctrl_pkg::st_delay;
    wire conv_end = state == conv_ctrl_pkg::st_convert && count_done;

    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            conv_ctrl_pkg::st_por: begin
                if (count_done) begin
                    next_state = conv_ctrl_pkg::st_convert;
                end
            end
            conv_ctrl_pkg::st_delay: begin
                if (start_cmd || cfg_write) begin
                    next_state = conv_ctrl_pkg::st_delay;
                end else if (count_done) begin
                    next_state = conv_ctrl_pkg::st_convert;
                end
            end
            conv_ctrl_pkg::st_convert: begin
                if (start_cmd || cfg_write) begin
                    next_state = conv_ctrl_pkg::st_delay;
                end else if (count_done) begin
                    if (sleep_pending || sleep_cmd) begin
                        next_state = conv_ctrl_pkg::st_down;
                    end else if (!continuous_run) begin
                        next_state = conv_ctrl_pkg::st_idle;
                    end else if (duty) begin
                        next_state = conv_ctrl_pkg::st_duty_wait;
                    end else begin
                        next_state = conv_ctrl_pkg::st_convert;
                    end
                end
            end
            conv_ctrl_pkg::st_duty_wait, conv_ctrl_pkg::st_idle: begin
                if (start_cmd || cfg_write) begin
                    next_state = conv_ctrl_pkg::st_delay;
                end else if (sleep_cmd) begin
                    next_state = conv_ctrl_pkg::st_down;
                end else if (state == conv_ctrl_pkg::st_duty_wait && count_done) begin
                    next_state = conv_ctrl_pkg::st_convert;
                end
            end
            conv_ctrl_pkg::st_down: begin
                if (start_cmd || cfg_write) begin
                    next_state = conv_ctrl_pkg::st_delay;
                end
            end
            default: next_state = conv_ctrl_pkg::st_por;
        endcase
    end

    logic [31:0] next_count;
    always_comb begin
        next_count = count - 32'h0000_0001;
        if (count_done) begin
            next_count = 32'h0000_0000;
        end
        if (next_state != state || (conv_end && next_state == conv_ctrl_pkg::st_convert)) begin
            case (next_state)
                conv_ctrl_pkg::st_delay: next_count = start_delay - 32'h0000_0001;
                conv_ctrl_pkg::st_convert: next_count = conv_cycles - 32'h0000_0001;
                conv_ctrl_pkg::st_duty_wait: next_count = duty_cycles - 32'h0000_0001;
                default: next_count = 32'h0000_0000;
            endcase
        end else if (state == conv_ctrl_pkg::st_delay && (start_cmd || cfg_write)) begin
            next_count = start_delay - 32'h0000_0001;
        end
    end

    // a start follows the mode bit; writes give one shot unless continuous conversions are running
    wire next_continuous = (start_cmd && !in_por) ? conversion_mode_bit
        : (cfg_write && !continuous_run) ? 1'b0
        : (state == conv_ctrl_pkg::st_down && cfg_write) ? 1'b0
        : continuous_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= conv_ctrl_pkg::st_por;
            count <= por_cycles - 1;
            continuous_run <= 1'b0;
            sleep_pending <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            continuous_run <= next_continuous;
            // sleep waits for the conversion end
            sleep_pending <= converting && (sleep_pending || sleep_cmd) && !conv_end;
        end
    end

    // apb writes; configuration survives power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config0 <= `RST_CONFIG0;
            config1 <= `RST_CONFIG1;
            config2 <= `RST_CONFIG2;
        end else if (apb_wr && apb_ok) begin
            if (sel_cfg0) begin
                config0 <= pwdata[7:0];
            end
            if (sel_cfg1) begin
                config1 <= pwdata[7:0];
            end
            if (sel_cfg2) begin
                config2 <= pwdata[7:0];
            end
        end
    end

    // temperature code is left-justified
    wire [15:0] next_result = temp_sensor_enable
        ? {afe_temp_code, {(16 - `TEMP_BITS){1'b0}}}
        : afe_sample;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 16'h0000;
        end else if (conv_end) begin
            result <= next_result;
        end
    end

    // a new result wins over the clearing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ready_n <= 1'b1;
        end else if (conv_end) begin
            result_ready_n <= 1'b0;
        end else if (sclk_rise) begin
            result_ready_n <= 1'b1;
        end
    end

    // result loads at select, or at a new result while no byte is in flight
    wire tx_load = cs_fall || (conv_end && bit_cnt == 3'd0 && !tx_active);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'd0;
            rx_shift <= 8'h00;
            tx_shift <= 16'h0000;
            tx_active <= 1'b0;
        end else if (!selected) begin
            // deselect resets the serial interface
            bit_cnt <= 3'd0;
            tx_active <= 1'b0;
            tx_shift <= conv_end ? next_result : result;
        end else begin
            if (sclk_fall) begin
                rx_shift <= rx_byte;
                bit_cnt <= bit_cnt + 3'd1;
            end
            if (tx_load) begin
                tx_shift <= conv_end ? next_result : result;
            end else if (sclk_rise) begin
                tx_shift <= {tx_shift[14:0], 1'b0};
                tx_active <= 1'b1;
            end
            if (byte_done && tx_active && tx_shift == 16'h0000) begin
                tx_active <= 1'b0;
            end
        end
    end

    // ready shows on data out until data bits shift
    logic next_dout;
    assign next_dout = (ready_on_dout && !tx_active) ? result_ready_n : tx_shift[15];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_ready_n <= 1'b1;
            serial_out_ready_n_oe <= 1'b0;
        end else begin
            serial_out_ready_n <= (conv_end && ready_on_dout && !tx_active) ? 1'b0 : next_dout;
            serial_out_ready_n_oe <= selected;
        end
    end

    // modulator clock divider
    logic [4:0] mod_cnt;
    wire mod_running = converting || state == conv_ctrl_pkg::st_por;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_cnt <= 5'd0;
            modulator_tick <= 1'b0;
        end else begin
            mod_cnt <= (!mod_running || mod_cnt >= mod_div - 5'd1) ? 5'd0 : mod_cnt + 5'd1;
            modulator_tick <= mod_running && mod_cnt == mod_div - 5'd1;
        end
    end

    // analog front end steering
    wire monitor = input_select_field == `MUX_REF_MONITOR
        || input_select_field == `MUX_SUPPLY_MONITOR;
    conv_ctrl_pkg::afe_ctrl_type next_afe;
    always_comb begin
        next_afe.input_select_field = input_select_field;
        next_afe.gain = config0[`F_GAIN_HI:`F_GAIN_LO];
        next_afe.gain_bypass = config0[`F_GAIN_BYPASS];
        next_afe.ref_select = ref_select;
        next_afe.measure_temp = temp_sensor_enable;
        if (monitor) begin
            next_afe.gain = 3'd0;
            next_afe.gain_bypass = 1'b1;
            // supply monitor has no external pair to keep
            next_afe.ref_select = (input_select_field == `MUX_SUPPLY_MONITOR)
                ? `REF_INTERNAL : ref_select;
        end
        if (temp_sensor_enable) begin
            next_afe.input_select_field = 4'h0;
            next_afe.gain = 3'd0;
            next_afe.gain_bypass = 1'b0;
            next_afe.ref_select = `REF_INTERNAL;
        end
        next_afe.powered = mod_running;
        next_afe.osc_on = mod_running;
        next_afe.excitation_enable = state != conv_ctrl_pkg::st_down;
        next_afe.switch_closed = switch_enable && state != conv_ctrl_pkg::st_down
            && state != conv_ctrl_pkg::st_por;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afe_ctrl <= '0;
        end else begin
            afe_ctrl <= next_afe;
        end
    end

    // apb read and answer: zero wait states
    wire [31:0] status_word = {24'h00_0000, continuous_run, sleep_pending, state};
    assign pready = 1'b1;
    assign pslverr = apb_access && !apb_ok;
    assign prdata = !(psel && !pwrite && apb_ok) ? 32'h0000_0000
        : sel_cfg0 ? {24'h00_0000, config0}
        : sel_cfg1 ? {24'h00_0000, config1}
        : sel_cfg2 ? {24'h00_0000, config2}
        : sel_status ? status_word
        : sel_result ? {16'h0000, result}
        : 32'h0000_0000;

endmodule : conv_ctrl
`default_nettype wire

/* File: test/conv_ctrl_checker.sv */
// port assertions of the converter sequencer
// assumes the bind below attaches it to conv_ctrl
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_checker #(
    parameter int unsigned por_cycles = 20
) (
    // clock and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    // serial and ready
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_out_ready_n_oe,
    input wire logic result_ready_n,
    // front end
    input wire conv_ctrl_pkg::afe_ctrl_type afe_ctrl,
    input wire logic modulator_tick
);
    int unsigned cyc;
    wire logic [3:0] isel = afe_ctrl.input_select_field;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // saturates, never wraps into power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cyc <= 0;
        else if (cyc < 32'd100000)
            cyc <= cyc + 1;
    end
    AST_MON_BYPASS: assert property (
        afe_ctrl.powered && isel[3:1] == 3'b110 |-> afe_ctrl.gain_bypass)
        else $error("monitor kept amplifier");
    AST_SUPPLY_REF: assert property (
        afe_ctrl.powered && isel == 4'hD |-> afe_ctrl.ref_select == 2'h0)
        else $error("supply ref not internal");
    AST_TEMP_CFG: assert property (
        afe_ctrl.measure_temp |-> isel == 4'h0 && afe_ctrl.gain == 3'h0
            && afe_ctrl.ref_select == 2'h0)
        else $error("temp mode kept config0");
    AST_READY_RISE: assert property (
        !result_ready_n && !cs_n && $rose(sclk) |-> ##[1:6] result_ready_n)
        else $error("ready not raised");
    AST_TICK_GAP: assert property (
        modulator_tick |=> !modulator_tick [*7])
        else $error("ticks too close");
    AST_OE_ON: assert property (
        $fell(cs_n) |-> ##[2:6] serial_out_ready_n_oe)
        else $error("data out not enabled");
    AST_POR_ERR: assert property (
        psel && penable && cyc < por_cycles |-> pslverr)
        else $error("access in power-up");
    AST_POR_READY: assert property (
        cyc < por_cycles |-> result_ready_n)
        else $error("ready fell in power-up");
endmodule : conv_ctrl_checker
bind conv_ctrl conv_ctrl_checker #(.por_cycles(por_cycles)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .cs_n(cs_n), .sclk(sclk), .serial_out_ready_n_oe(serial_out_ready_n_oe),
    .result_ready_n(result_ready_n), .afe_ctrl(afe_ctrl), .modulator_tick(modulator_tick)
);
`default_nettype wire

/* File: test/spi_host_model.sv */
// host serial controller sending command bytes in spi mode 1
// assumes pclk; pins change just after its rising edge
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    // clock
    input wire logic pclk,
    // serial pins
    output logic cs_n,
    output logic sclk,
    output logic din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // released line toggles so a stale bit never reads as valid
    always @(posedge pclk)
        if (cs_n)
            din <= ~din;
    task automatic send_byte(input logic [7:0] b);
        @(posedge pclk);
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (5) @(posedge pclk);
            sclk <= 1'b1;
            din <= b[i];
            repeat (5) @(posedge pclk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge pclk);
        cs_n <= 1'b1;
    endtask : send_byte
endmodule : spi_host_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench of the converter sequencer
// assumes the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_params.svh"
module testbench;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, z = 32'h0000_0000;
    logic [15:0] afe_sample;
    logic [13:0] afe_temp_code;
    logic [3:0] codes [4] = '{4'hC, 4'hD, 4'hE, 4'h3};
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cs_n, sclk, din, out_n, out_n_oe, result_ready_n, tick;
    wire conv_ctrl_pkg::afe_ctrl_type afe_ctrl;
    int errors = 0, compares = 0, el, cycles = 0, seed = 32'h8375_cdc3;
    conv_ctrl #(.por_cycles(20), .conv_div(256)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cs_n(cs_n), .sclk(sclk), .din(din), .serial_out_ready_n(out_n),
        .serial_out_ready_n_oe(out_n_oe), .result_ready_n(result_ready_n),
        .afe_sample(afe_sample), .afe_temp_code(afe_temp_code), .afe_ctrl(afe_ctrl),
        .modulator_tick(tick)
    );
    spi_host_model host_u (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .din(din));
    initial forever #5 pclk = ~pclk;
    function automatic logic exp_bypass(input logic [3:0] isel);
        return isel == `MUX_REF_MONITOR || isel == `MUX_SUPPLY_MONITOR;
    endfunction : exp_bypass
    function automatic logic [31:0] exp_temp(input logic [13:0] code);
        return {16'h0000, code, 2'b00};
    endfunction : exp_temp
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    task automatic tally_and_finish();
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_fall(input string name);
        el = 0;
        while (result_ready_n !== 1'b0 && el < 3000) begin
            @(posedge pclk);
            el++;
        end
        cmp(name, 32'h0, result_ready_n);
    endtask : wait_fall
    // 160 clocks hold whole tick periods
    task automatic tick_count(input int exp);
        el = 0;
        repeat (160) begin
            @(posedge pclk);
            el += int'(tick === 1'b1);
        end
        cmp("ticks", exp, el);
    endtask : tick_count
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, afe_sample, afe_temp_code} <= '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_STATUS, z);
        cmp("por_err", 32'h1, err);
        wait_fall("por_conv");
        apb(1'b0, `OFS_STATUS, z);
        cmp("idle", 32'h10, rd);
        cmp("osc_off", 32'h0, afe_ctrl.osc_on);
        apb(1'b0, 12'h018, z);
        cmp("unmapped", 32'h1, err);
        codes[3] = {1'b0, 3'($random(seed))};
        foreach (codes[i]) begin
            afe_sample <= 16'($random(seed));
            host_u.send_byte(8'h00);
            apb(1'b1, `OFS_CONFIG0, {24'h00_0000, codes[i], 4'hA});
            repeat (215) @(posedge pclk);
            cmp("bypass", exp_bypass(codes[i]), afe_ctrl.gain_bypass);
            cmp("isel", codes[i], afe_ctrl.input_select_field);
            wait_fall("shot");
            apb(1'b0, `OFS_RESULT, z);
            cmp("result", {16'h0000, afe_sample}, rd);
        end
        host_u.send_byte(8'h00);
        apb(1'b1, `OFS_CONFIG0, z);
        repeat (100) @(posedge pclk);
        apb(1'b1, `OFS_CONFIG0, z);
        wait_fall("restart");
        cmp("restart_len", 32'h1, el > 1000);
        afe_temp_code <= 14'($random(seed));
        host_u.send_byte(8'h00);
        apb(1'b1, `OFS_CONFIG1, 32'h0000_0002);
        wait_fall("temp");
        apb(1'b0, `OFS_RESULT, z);
        cmp("temp", exp_temp(afe_temp_code), rd);
        cmp("dout", afe_temp_code[13], out_n);
        apb(1'b1, `OFS_CONFIG1, 32'h0000_0004);
        host_u.send_byte(8'h09);
        wait_fall("cont_first");
        afe_sample <= 16'($random(seed));
        host_u.send_byte(8'h00);
        wait_fall("cont_next");
        apb(1'b0, `OFS_RESULT, z);
        cmp("cont_result", {16'h0000, afe_sample}, rd);
        apb(1'b0, `OFS_STATUS, z);
        cmp("cont_bit", 32'h1, rd[7]);
        tick_count(10);
        apb(1'b1, `OFS_CONFIG1, 32'h0000_0014);
        repeat (120) @(posedge pclk);
        tick_count(20);
        host_u.send_byte(8'h03);
        el = 0;
        do begin
            apb(1'b0, `OFS_STATUS, z);
            el++;
        end while (rd[5:0] !== 6'h20 && el < 400);
        cmp("down", 32'h20, rd[5:0]);
        @(posedge pclk);
        cmp("down_pwr", 32'h0, {afe_ctrl.powered, afe_ctrl.switch_closed});
        host_u.send_byte(8'h00);
        apb(1'b1, `OFS_CONFIG1, 32'h0000_000C);
        wait_fall("wake");
        repeat (250) @(posedge pclk);
        apb(1'b0, `OFS_STATUS, z);
        cmp("one_shot", 32'h10, rd[5:0]);
        host_u.send_byte(8'h09);
        wait_fall("duty");
        apb(1'b0, `OFS_STATUS, z);
        cmp("duty", 32'h08, rd[5:0]);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
